// >>> rtl/sqsr_regs.sv
// Purpose: serial-reached self-test, fault pin and qa status registers
// Assumes: serial mode 0, pins asynchronous, test engines on clk_i
// Notes:   miso is a three-signal pin, enable high while driven
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (R1) qa error total read at bits 11:8, read only
// (R2) current qa sequence number at bits 7:4, resets to zero
// (R3) previous expected qa answer at bits 3:0, resets to all ones
// (R4) force bit 0 drives fault indicator low; zero means normal
// (R5) writing one to rerun bit 4 requests both self-tests again
// (R6) rerun honoured only while a self-test has been judged failed
// (R7) rerun bit clears itself when the self-tests restart
// (R8) no failure means a rerun write starts nothing
// (R9) pass flags bit 5 and bit 1 show logic and analog results
// (R10) finished flags bit 4 and bit 0 set only on completion
// (R11) serial port silent for frames begun while the logic self-test runs
// (R12) status registers ignore writes
// (R13) result and finished flags hold until rerun or reset
module sqsr_regs (
  input  wire logic               clk_i,
  input  wire logic               rstn_i,
  input  wire logic               spi_sclk_i,
  input  wire logic               spi_csn_i,
  input  wire logic               spi_mosi_i,
  output logic                    spi_miso_o,
  output logic                    spi_miso_oe_o,
  input  wire sqsr_pkg::sqsr_qa_t   qa_i,
  input  wire sqsr_pkg::sqsr_bist_t logic_selftest_i,
  input  wire sqsr_pkg::sqsr_bist_t analog_selftest_i,
  input  wire logic               fault_i,
  output logic                    fault_ind_n_o,
  output logic                    selftest_restart_o,
  input  wire logic               fet_unlock_i,
  output sqsr_pkg::sqsr_fet_cfg_t fet_cfg_o,
  output logic                    fet_start_o,
  output logic                    fet_save_clear_o
);

  logic [2:0]            pin_a_q;
  logic [2:0]            pin_b_q;
  logic [2:0]            pin_c_q;
  logic [2:0]            pin_q;
  logic [2:0]            pin_prev_q;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  cs_fall;
  logic                  cs_rise;
  sqsr_pkg::sqsr_frame_t fr_q;
  logic [4:0]            cnt_q;
  logic [23:0]           sh_q;
  logic [15:0]           tx_q;
  logic                  miso_q;
  logic                  miso_oe_q;
  logic                  wr_q;
  logic [7:0]            wr_addr_q;
  logic [15:0]           wr_data_q;
  logic                  force_q;
  logic                  rerun_q;
  logic                  restart_q;
  logic                  lend_q;
  logic                  lpass_q;
  logic                  aend_q;
  logic                  apass_q;
  logic                  failed;
  sqsr_pkg::sqsr_qa_t    qa_q;
  sqsr_pkg::sqsr_fet_cfg_t fet_q;
  logic                  fet_start_q;
  logic                  save_cl_q;
  logic                  fault_n_q;

  // pin synchroniser, value moves once stages two and three agree
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_a_q    <= 3'h2;
      pin_b_q    <= 3'h2;
      pin_c_q    <= 3'h2;
      pin_q      <= 3'h2;
      pin_prev_q <= 3'h2;
    end else begin
      pin_a_q    <= {spi_mosi_i, spi_csn_i, spi_sclk_i};
      pin_b_q    <= pin_a_q;
      pin_c_q    <= pin_b_q;
      pin_q      <= (pin_q & (pin_b_q ^ pin_c_q))
                  | (pin_c_q & ~(pin_b_q ^ pin_c_q));
      pin_prev_q <= pin_q;
    end
  end

  assign sclk_rise = pin_q[sqsr_pkg::PIN_SCLK]
                   & ~pin_prev_q[sqsr_pkg::PIN_SCLK];
  assign sclk_fall = ~pin_q[sqsr_pkg::PIN_SCLK]
                   & pin_prev_q[sqsr_pkg::PIN_SCLK];
  assign cs_fall   = ~pin_q[sqsr_pkg::PIN_CSN]
                   & pin_prev_q[sqsr_pkg::PIN_CSN];
  assign cs_rise   = pin_q[sqsr_pkg::PIN_CSN]
                   & ~pin_prev_q[sqsr_pkg::PIN_CSN];

  // read decode, unmapped and write-only bits read zero
  function automatic logic [15:0] rd_word(input logic [7:0] a);
    logic [15:0] w;
    w = 16'h0000;
    unique case (a)
      sqsr_pkg::ADDR_DIAG | sqsr_pkg::READ_FLAG:
        w[sqsr_pkg::DIAG_FORCE] = force_q;
      sqsr_pkg::ADDR_FET1 | sqsr_pkg::READ_FLAG: begin
        w[sqsr_pkg::FET_MANUAL] = fet_q.manual_test;
        w[sqsr_pkg::FET_RMID_LSB +: 3] = fet_q.rmid_on;
        w[sqsr_pkg::FET_NDIAG] = fet_q.ndiag_sel;
        w[sqsr_pkg::FET_COMP] = fet_q.comp_sel;
        w[sqsr_pkg::FET_TYPE_LSB +: 2] = fet_q.test_type;
        w[sqsr_pkg::FET_STOP] = fet_q.stop;
      end
      sqsr_pkg::ADDR_PROG: begin
        w[sqsr_pkg::PROG_ACC_LSB +: 4] = qa_q.acc;  // R1
        w[sqsr_pkg::PROG_SEQ_LSB +: 4] = qa_q.seq;  // R2
        w[sqsr_pkg::PROG_PRV_LSB +: 4] = qa_q.prev; // R3
      end
      sqsr_pkg::ADDR_STAT: begin
        w[sqsr_pkg::STAT_LPASS] = lpass_q;
        w[sqsr_pkg::STAT_LEND]  = lend_q;
        w[sqsr_pkg::STAT_APASS] = apass_q;
        w[sqsr_pkg::STAT_AEND]  = aend_q;
      end
      default: w = 16'h0000;
    endcase
    return w;
  endfunction : rd_word

  // frame engine
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fr_q      <= sqsr_pkg::SQSR_IDLE;
      cnt_q     <= 5'h00;
      sh_q      <= 24'h000000;
      tx_q      <= 16'h0000;
      miso_q    <= 1'b0;
      wr_q      <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 16'h0000;
    end else begin
      wr_q <= 1'b0;
      unique case (fr_q)
        sqsr_pkg::SQSR_IDLE: begin
          if (cs_fall) begin
            fr_q   <= logic_selftest_i.busy ? sqsr_pkg::SQSR_SKIP
                                            : sqsr_pkg::SQSR_SHIFT; // R11
            cnt_q  <= 5'h00;
            sh_q   <= 24'h000000;
            miso_q <= 1'b0;
          end
        end
        sqsr_pkg::SQSR_SHIFT: begin
          if (cs_rise) begin
            fr_q      <= sqsr_pkg::SQSR_IDLE;
            wr_q      <= (cnt_q == sqsr_pkg::FRAME_BITS);
            wr_addr_q <= sh_q[23:16];
            wr_data_q <= sh_q[15:0];
          end else if (sclk_rise) begin
            sh_q <= {sh_q[22:0], pin_q[sqsr_pkg::PIN_MOSI]};
            if (cnt_q != sqsr_pkg::FRAME_BITS) begin
              cnt_q <= cnt_q + 5'h01;
            end
            if (cnt_q == sqsr_pkg::ADDR_LAST) begin
              tx_q <= rd_word({sh_q[6:0], pin_q[sqsr_pkg::PIN_MOSI]});
            end
          end else if (sclk_fall && cnt_q > sqsr_pkg::ADDR_LAST) begin
            miso_q <= tx_q[15];
            tx_q   <= {tx_q[14:0], 1'b0};
          end
        end
        sqsr_pkg::SQSR_SKIP: begin
          if (cs_rise) begin
            fr_q <= sqsr_pkg::SQSR_IDLE;
          end
        end
        default: fr_q <= sqsr_pkg::SQSR_IDLE;
      endcase
    end
  end

  // miso driven only inside an accepted frame
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      miso_oe_q <= 1'b0;
    end else begin
      miso_oe_q <= (fr_q == sqsr_pkg::SQSR_SHIFT)
                 & ~pin_q[sqsr_pkg::PIN_CSN]; // R11
    end
  end

  assign failed = (lend_q & ~lpass_q) | (aend_q & ~apass_q);

  // diag register and rerun request
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      force_q   <= 1'b0;
      rerun_q   <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      restart_q <= rerun_q;
      if (rerun_q) begin
        rerun_q <= 1'b0; // R7
      end else if (wr_q && wr_addr_q == sqsr_pkg::ADDR_DIAG) begin
        rerun_q <= wr_data_q[sqsr_pkg::DIAG_RERUN] & failed; // R5 R6 R8
      end
      if (wr_q && wr_addr_q == sqsr_pkg::ADDR_DIAG) begin
        force_q <= wr_data_q[sqsr_pkg::DIAG_FORCE];
      end
    end
  end

  // self-test result and finished flags, completion beats restart
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lend_q  <= 1'b0;
      lpass_q <= 1'b0;
      aend_q  <= 1'b0;
      apass_q <= 1'b0;
    end else begin
      if (logic_selftest_i.done) begin
        lend_q  <= 1'b1;                   // R10
        lpass_q <= logic_selftest_i.pass;  // R9
      end else if (restart_q) begin
        lend_q  <= 1'b0;                   // R13
        lpass_q <= 1'b0;
      end
      if (analog_selftest_i.done) begin
        aend_q  <= 1'b1;                   // R10
        apass_q <= analog_selftest_i.pass; // R9
      end else if (restart_q) begin
        aend_q  <= 1'b0;                   // R13
        apass_q <= 1'b0;
      end
    end
  end

  // qa progress snapshot, never written from the port
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      qa_q <= '{acc: sqsr_pkg::ACC_RST, seq: sqsr_pkg::SEQ_RST,
                prev: sqsr_pkg::PRV_RST}; // R2 R3
    end else begin
      qa_q <= qa_i; // R1 R12
    end
  end

  // fet control, lockable bits need the unlock level
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fet_q       <= '0;
      fet_start_q <= 1'b0;
      save_cl_q   <= 1'b0;
    end else begin
      fet_start_q <= 1'b0;
      save_cl_q   <= 1'b0;
      if (wr_q && wr_addr_q == sqsr_pkg::ADDR_FET1) begin
        fet_q.ndiag_sel <= wr_data_q[sqsr_pkg::FET_NDIAG];
        fet_q.comp_sel  <= wr_data_q[sqsr_pkg::FET_COMP];
        fet_q.test_type <= wr_data_q[sqsr_pkg::FET_TYPE_LSB +: 2];
        fet_q.stop      <= wr_data_q[sqsr_pkg::FET_STOP];
        save_cl_q       <= wr_data_q[sqsr_pkg::FET_SAVE_CL];
        fet_start_q     <= fet_unlock_i
                         & wr_data_q[sqsr_pkg::FET_START]
                         & ~wr_data_q[sqsr_pkg::FET_STOP];
        if (fet_unlock_i) begin
          fet_q.manual_test <= wr_data_q[sqsr_pkg::FET_MANUAL];
          fet_q.rmid_on     <= wr_data_q[sqsr_pkg::FET_RMID_LSB +: 3];
        end
      end
      if (!fet_unlock_i) begin
        fet_q.manual_test <= 1'b0;
        fet_q.rmid_on     <= 3'h0;
      end
    end
  end

  // fault indicator, active low
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_n_q <= 1'b1;
    end else begin
      fault_n_q <= ~(force_q | fault_i); // R4
    end
  end

  assign spi_miso_o         = miso_q;
  assign spi_miso_oe_o      = miso_oe_q;
  assign fault_ind_n_o      = fault_n_q;
  assign selftest_restart_o = restart_q;
  assign fet_cfg_o          = fet_q;
  assign fet_start_o        = fet_start_q;
  assign fet_save_clear_o   = save_cl_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_force_low: assert property (force_q |=> !fault_ind_n_o) // R4
    else $error("forced fault indicator not low");
  a_fault_normal: assert property ( // R4
    !force_q && !fault_i |=> fault_ind_n_o)
    else $error("fault indicator low without cause");
  a_restart_cause: assert property ( // R6
    selftest_restart_o |-> $past(failed, 2))
    else $error("restart without a failed self-test");
  a_rerun_request: assert property ( // R5
    wr_q && wr_addr_q == sqsr_pkg::ADDR_DIAG && failed && !rerun_q
    && wr_data_q[sqsr_pkg::DIAG_RERUN] |=> ##1 selftest_restart_o)
    else $error("rerun request not carried out");
  a_no_start_ok: assert property ( // R8
    !failed && !rerun_q |=> !rerun_q ##1 !selftest_restart_o)
    else $error("self-test restarted with no failure");
  a_rerun_clears: assert property ( // R7
    selftest_restart_o |-> !rerun_q)
    else $error("rerun bit not cleared on restart");
  a_busy_silent: assert property ( // R11
    fr_q == sqsr_pkg::SQSR_SKIP |=> !spi_miso_oe_o && !wr_q)
    else $error("port answered during logic self-test");
  a_flag_capture: assert property ( // R9 R10
    logic_selftest_i.done |=> lend_q
    && lpass_q == $past(logic_selftest_i.pass))
    else $error("logic self-test flags not captured");
  a_flag_hold: assert property ( // R13
    !restart_q && !analog_selftest_i.done |=> $stable(aend_q)
    && $stable(apass_q))
    else $error("analog self-test flags changed");
  a_qa_view: assert property ( // R1 R2 R3
    1'b1 |=> qa_q == $past(qa_i))
    else $error("qa progress view wrong");
  a_status_ro: assert property ( // R12
    wr_q && wr_addr_q == sqsr_pkg::ADDR_STAT && !restart_q
    && !logic_selftest_i.done |=> $stable(lend_q))
    else $error("status changed by a write");

  c_restart: cover property (selftest_restart_o);
  c_read_frame: cover property (
    fr_q == sqsr_pkg::SQSR_SHIFT && cnt_q == sqsr_pkg::FRAME_BITS);
  c_write_diag: cover property (
    wr_q && wr_addr_q == sqsr_pkg::ADDR_DIAG);
  c_skip_frame: cover property (fr_q == sqsr_pkg::SQSR_SKIP);

endmodule : sqsr_regs

`default_nettype wire

// >>> rtl/sqsr_pkg.sv
// Purpose: shared constants and types for the self-test and qa status bank
// Assumes: 24-bit serial frames, 8-bit address then 16-bit data, msb first
// Notes:   read address is the write address with the read flag set
`default_nettype none

package sqsr_pkg;

  // frame shape
  localparam int unsigned DW         = 16;
  localparam logic [4:0]  FRAME_BITS = 5'h18;
  localparam logic [4:0]  ADDR_LAST  = 5'h07;

  // addresses
  localparam logic [7:0] ADDR_DIAG = 8'h54;
  localparam logic [7:0] ADDR_FET1 = 8'h5c;
  localparam logic [7:0] ADDR_PROG = 8'hd0;
  localparam logic [7:0] ADDR_STAT = 8'hd8;
  localparam logic [7:0] READ_FLAG = 8'h80;

  // pin slots in the synchroniser
  localparam int PIN_SCLK = 0;
  localparam int PIN_CSN  = 1;
  localparam int PIN_MOSI = 2;

  // diag fields
  localparam int DIAG_FORCE = 0;
  localparam int DIAG_RERUN = 4;

  // status fields
  localparam int STAT_LPASS = 5;
  localparam int STAT_LEND  = 4;
  localparam int STAT_APASS = 1;
  localparam int STAT_AEND  = 0;

  // progress fields and reset values
  localparam int         PROG_ACC_LSB = 8;
  localparam int         PROG_SEQ_LSB = 4;
  localparam int         PROG_PRV_LSB = 0;
  localparam logic [3:0] ACC_RST      = 4'h0;
  localparam logic [3:0] SEQ_RST      = 4'h0;
  localparam logic [3:0] PRV_RST      = 4'hf;

  // fet control fields
  localparam int FET_MANUAL   = 11;
  localparam int FET_RMID_LSB = 8;
  localparam int FET_SAVE_CL  = 7;
  localparam int FET_NDIAG    = 5;
  localparam int FET_COMP     = 4;
  localparam int FET_TYPE_LSB = 2;
  localparam int FET_START    = 1;
  localparam int FET_STOP     = 0;

  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] seq;
    logic [3:0] prev;
  } sqsr_qa_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic pass;
  } sqsr_bist_t;

  typedef struct packed {
    logic       manual_test;
    logic [2:0] rmid_on;
    logic       ndiag_sel;
    logic       comp_sel;
    logic [1:0] test_type;
    logic       stop;
  } sqsr_fet_cfg_t;

  typedef enum logic [1:0] {
    SQSR_IDLE,
    SQSR_SHIFT,
    SQSR_SKIP
  } sqsr_frame_t;

endpackage : sqsr_pkg

`default_nettype wire

// >>> tb/sqsr_host.sv
// Purpose: host model driving the serial register port
// Assumes: mode 0 frames of 24 bits, each sclk level held 8 clocks
// Notes:   mosi toggles while deselected so no stale level is seen
`timescale 1ns/1ps
`default_nettype none
module sqsr_host (
  input  wire logic clk_i,
  input  wire logic miso_i,
  input  wire logic miso_oe_i,
  output logic      sclk_o,
  output logic      csn_o,
  output logic      mosi_o
);
  initial begin
    sclk_o = 1'b0;
    csn_o  = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic xfer(input logic [7:0] addr, input logic [15:0] wdata,
                      output logic [15:0] rdata, output logic oe_seen);
    logic [23:0] frame;
    frame   = {addr, wdata};
    rdata   = 16'h0000;
    oe_seen = 1'b0;
    @(posedge clk_i);
    csn_o <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sclk_o <= 1'b0;
      mosi_o <= frame[i];
      repeat (8) @(posedge clk_i);
      if (i < 16) begin
        rdata[i] = miso_i;
        oe_seen  = oe_seen | miso_oe_i;
      end
      sclk_o <= 1'b1;
      repeat (8) @(posedge clk_i);
    end
    sclk_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    csn_o  <= 1'b1;
    mosi_o <= ~mosi_o;
    repeat (12) @(posedge clk_i);
  endtask : xfer
endmodule : sqsr_host
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the status and diagnosis registers
// Assumes: host model frames, 40 MHz clock
// Notes:   pulse outputs are counted by an edge monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; \
  if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module tb_top;
  logic                    clk, rstn, sclk, csn, mosi, miso, miso_oe;
  logic                    fault, unlock, fault_n, restart, fstart, fsave;
  sqsr_pkg::sqsr_qa_t      qa;
  sqsr_pkg::sqsr_bist_t    lst, ast;
  sqsr_pkg::sqsr_fet_cfg_t fcfg;
  int                      n_fail, samples_checked, n_rst, n_fst, n_fsv;

  sqsr_host host (.clk_i(clk), .miso_i(miso), .miso_oe_i(miso_oe),
                  .sclk_o(sclk), .csn_o(csn), .mosi_o(mosi));

  sqsr_regs dut (.clk_i(clk), .rstn_i(rstn), .spi_sclk_i(sclk),
    .spi_csn_i(csn), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .spi_miso_oe_o(miso_oe), .qa_i(qa), .logic_selftest_i(lst),
    .analog_selftest_i(ast), .fault_i(fault), .fault_ind_n_o(fault_n),
    .selftest_restart_o(restart), .fet_unlock_i(unlock),
    .fet_cfg_o(fcfg), .fet_start_o(fstart), .fet_save_clear_o(fsave));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (restart === 1'b1) n_rst++;
    if (fstart === 1'b1) n_fst++;
    if (fsave === 1'b1) n_fsv++;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        oe;
    host.xfer(a, 16'h0000, d, oe);
    `CHK("read word", exp, d)
    `CHK("read enable", 1'b1, oe)
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] junk;
    logic        oe;
    host.xfer(a, d, junk, oe);
    repeat (12) @(posedge clk);
  endtask : wr

  task automatic pulse(input logic dl, lp, da, ap);
    @(posedge clk);
    lst <= {1'b0, dl, lp};
    ast <= {1'b0, da, ap};
    @(posedge clk);
    lst <= 3'b000;
    ast <= 3'b000;
    repeat (2) @(posedge clk);
  endtask : pulse

  task automatic t_qa();
    @(posedge clk);
    qa <= 12'h5a3;
    repeat (3) @(posedge clk);
    rd(8'hd0, 16'h05a3);
    wr(8'hd0, 16'hffff);
    wr(8'hd8, 16'hffff);
    rd(8'hd0, 16'h05a3);
    rd(8'hd8, 16'h0000);
  endtask : t_qa

  task automatic t_force();
    wr(8'h54, 16'h0001);
    `CHK("fault ind", 1'b0, fault_n)
    rd(8'hd4, 16'h0001);
    wr(8'h54, 16'h0000);
    `CHK("fault ind", 1'b1, fault_n)
    @(posedge clk);
    fault <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("fault ind", 1'b0, fault_n)
    fault <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : t_force

  task automatic t_bist(input logic lp, input logic ap);
    int n0;
    pulse(1'b1, lp, 1'b1, ap);
    rd(8'hd8, {10'h000, lp, 3'b100, ap, 1'b1});
    repeat (20) @(posedge clk);
    rd(8'hd8, {10'h000, lp, 3'b100, ap, 1'b1});
    n0 = n_rst;
    wr(8'h54, 16'h0010);
    repeat (30) @(posedge clk);
    `CHK("restarts", n0 + int'(!(lp & ap)), n_rst)
    rd(8'hd4, 16'h0000);
    if (!(lp & ap)) begin
      rd(8'hd8, 16'h0000);
      pulse(1'b0, 1'b0, 1'b1, 1'b1);
      rd(8'hd8, 16'h0003);
    end
  endtask : t_bist

  task automatic t_busy();
    logic [15:0] d;
    logic        oe;
    @(posedge clk);
    lst <= 3'b100;
    host.xfer(8'hd8, 16'h0000, d, oe);
    `CHK("enable busy", 1'b0, oe)
    wr(8'h54, 16'h0001);
    lst <= 3'b000;
    repeat (8) @(posedge clk);
    `CHK("fault ind", 1'b1, fault_n)
    rd(8'hd4, 16'h0000);
  endtask : t_busy

  task automatic t_fet();
    int ns, nv;
    ns = n_fst;
    nv = n_fsv;
    @(posedge clk);
    unlock <= 1'b1;
    wr(8'h5c, 16'h0fb6);
    `CHK("fet cfg", 9'h1fa, fcfg)
    `CHK("fet start", ns + 1, n_fst)
    `CHK("fet clear", nv + 1, n_fsv)
    rd(8'hdc, 16'h0f34);
    wr(8'h5c, 16'h0f03);
    `CHK("fet cfg", 9'h1e1, fcfg)
    unlock <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("fet cfg", 9'h001, fcfg)
    wr(8'h5c, 16'h0f02);
    `CHK("fet cfg", 9'h000, fcfg)
    `CHK("fet start", ns + 1, n_fst)
  endtask : t_fet

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    summarize();
  end

  initial begin
    rstn = 1'b0;
    qa = 12'h00f;
    lst = 3'b000;
    ast = 3'b000;
    fault = 1'b0;
    unlock = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    n_rst = 0;
    n_fst = 0;
    n_fsv = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    rd(8'hd0, 16'h000f);
    rd(8'hd8, 16'h0000);
    rd(8'hd4, 16'h0000);
    t_qa();
    t_force();
    t_bist(1'b1, 1'b0);
    t_bist(1'b0, 1'b1);
    t_bist(1'b1, 1'b1);
    t_busy();
    t_fet();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
